// [ccm_compare_top.sv]
// Compare channel: timer match actions, special event trigger, AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "ccm_cfg.svh"

module ccm_compare_top #(
    parameter int CHANNEL_IDX = 10,
    parameter int ADDR_W      = `CCM_ADDR_W
) (
    input  wire logic                sys_clk,
    input  wire logic                rst,
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire ccm_pkg::ccm_timer_t timer1_in,
    input  wire ccm_pkg::ccm_timer_t timer_alt_in,
    input  wire logic                pin_direction_bit,
    input  wire logic                adc_enable,
    output logic                     compare_pin_out,
    output logic                     compare_pin_oe,
    output logic                     special_event_trig,
    output logic                     adc_start,
    output logic                     timer1_reset,
    output logic                     timer_alt_reset,
    output logic                     irq
);

    localparam logic       SPEV_EN   = (CHANNEL_IDX == `CCM_SPEV_CHANNEL);
    localparam logic [3:0] ALT_TIMER = (CHANNEL_IDX <= `CCM_ALT_SPLIT) ?
                                       `CCM_TIMER_LOW : `CCM_TIMER_HIGH;

    ccm_pkg::ccm_ctrl_t   ctrl_q;
    logic [15:0]          cmp_q;
    ccm_pkg::ccm_events_t status_q;
    ccm_pkg::ccm_events_t mask_q;
    ccm_pkg::ccm_events_t ev_set;
    ccm_pkg::ccm_events_t ev_clr;
    logic                 latch_q;
    logic                 pin_oe_q;
    logic                 pending_q;

    logic                 aw_held_q;
    logic [ADDR_W-1:0]    awaddr_q;
    logic                 w_held_q;
    logic [31:0]          wdata_q;
    logic [3:0]           wstrb_q;
    logic                 bvalid_q;
    logic [1:0]           bresp_q;
    logic                 rvalid_q;
    logic [31:0]          rdata_q;
    logic [1:0]           rresp_q;

    logic                 do_write;
    logic                 do_read;
    logic                 wr_ctrl;
    logic                 ctrl_zero_wr;
    logic                 wr_hit;
    logic [31:0]          rd_data;
    logic                 rd_hit;

    logic [15:0]          sel_count;
    logic                 sel_tick;
    logic                 is_cmp;
    logic                 drives_pin;
    logic                 match;
    logic                 match_rise;
    logic                 timer_reset;

    // ------------------------------------------------------------------
    // Timer selection and match detection
    // ------------------------------------------------------------------
    // Alternate timer is 3 or 5 depending on channel number
    assign sel_count = ctrl_q.tsel ? timer_alt_in.count : timer1_in.count;
    assign sel_tick  = ctrl_q.tsel ? timer_alt_in.tick : timer1_in.tick;

    always_comb
    begin
        is_cmp     = 1'b0;
        drives_pin = 1'b0;
        case (ctrl_q.mode)
            `CCM_MODE_TOGGLE, `CCM_MODE_SET, `CCM_MODE_CLR:
            begin
                is_cmp     = 1'b1;
                drives_pin = 1'b1;
            end
            `CCM_MODE_SWI, `CCM_MODE_SPEV:
            begin
                is_cmp     = 1'b1;
                drives_pin = 1'b0;
            end
            default:
            begin
                is_cmp     = 1'b0;
                drives_pin = 1'b0;
            end
        endcase
    end

    // Runs only while sys_clk runs; a stopped clock halts all matching
    ccm_match_unit #(
        .W          (16)
    ) u_match (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .enable     (is_cmp),
        .count      (sel_count),
        .value      (cmp_q),
        .match      (match),
        .match_rise (match_rise)
    );

    // ------------------------------------------------------------------
    // Special event trigger and deferred timer reset
    // ------------------------------------------------------------------
    // Other channels treat mode 1011 as flag only
    assign special_event_trig = match_rise && SPEV_EN &&
                                (ctrl_q.mode == `CCM_MODE_SPEV);
    assign adc_start          = special_event_trig && adc_enable;

    // Reset strobe is separate from overflow, so no overflow flag rises
    assign timer_reset     = pending_q && sel_tick && match;
    assign timer1_reset    = timer_reset && !ctrl_q.tsel;
    assign timer_alt_reset = timer_reset && ctrl_q.tsel;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            pending_q <= 1'b0;
        else if (special_event_trig)
            pending_q <= 1'b1;
        else if (!match || sel_tick)
            pending_q <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Compare output latch and pin drive
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            latch_q <= 1'b0;
        else if (ctrl_zero_wr)
            latch_q <= 1'b0;
        else if (match_rise)
        begin
            case (ctrl_q.mode)
                `CCM_MODE_TOGGLE: latch_q <= ~latch_q;
                `CCM_MODE_SET:    latch_q <= 1'b1;
                `CCM_MODE_CLR:    latch_q <= 1'b0;
                default:          latch_q <= latch_q;
            endcase
        end
    end

    // Pin is driven only when its direction bit selects output
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            pin_oe_q <= 1'b0;
        else
            pin_oe_q <= drives_pin && !pin_direction_bit;
    end

    assign compare_pin_out = latch_q;
    assign compare_pin_oe  = pin_oe_q;

    // ------------------------------------------------------------------
    // Sticky events, read-to-clear, masked interrupt
    // ------------------------------------------------------------------
    assign ev_set = '{spev:  special_event_trig,
                      match: match_rise};
    assign ev_clr       = (do_read && s_axi_araddr == `CCM_OFF_STATUS) ?
                          ccm_pkg::ccm_events_t'(2'h3) : ccm_pkg::ccm_events_t'(2'h0);

    // Set wins over a read clear in the same cycle
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            status_q <= ccm_pkg::ccm_events_t'(2'h0);
        else
            status_q <= (status_q & ~ev_clr) | ev_set;
    end

    assign irq = |(status_q & mask_q);

    // ------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign do_write      = aw_held_q && w_held_q && !bvalid_q;
    assign wr_ctrl       = do_write && (awaddr_q == `CCM_OFF_CTRL) && wstrb_q[0];
    assign ctrl_zero_wr  = wr_ctrl && (wdata_q[7:0] == 8'h00);
    assign wr_hit        = (awaddr_q == `CCM_OFF_CTRL) || (awaddr_q == `CCM_OFF_CMP) ||
                           (awaddr_q == `CCM_OFF_STATUS) || (awaddr_q == `CCM_OFF_MASK) ||
                           (awaddr_q == `CCM_OFF_STATE);

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            aw_held_q <= 1'b0;
            awaddr_q  <= '0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
        end
        else if (do_write)
            aw_held_q <= 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            w_held_q <= 1'b0;
            wdata_q  <= 32'h00000000;
            wstrb_q  <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
        end
        else if (do_write)
            w_held_q <= 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            bvalid_q <= 1'b0;
            bresp_q  <= `CCM_RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? `CCM_RESP_OKAY : `CCM_RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_q <= 1'b0;
    end

    // Register writes; status and state are read-only
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ctrl_q <= ccm_pkg::ccm_ctrl_t'(`CCM_CTRL_RST);
            cmp_q  <= `CCM_CMP_RST;
            mask_q <= ccm_pkg::ccm_events_t'(`CCM_MASK_RST);
        end
        else if (do_write)
        begin
            if (wr_ctrl)
                ctrl_q <= ccm_pkg::ccm_ctrl_t'(wdata_q[4:0]);
            if (awaddr_q == `CCM_OFF_CMP && wstrb_q[0])
                cmp_q[7:0] <= wdata_q[7:0];
            if (awaddr_q == `CCM_OFF_CMP && wstrb_q[1])
                cmp_q[15:8] <= wdata_q[15:8];
            if (awaddr_q == `CCM_OFF_MASK && wstrb_q[0])
                mask_q <= ccm_pkg::ccm_events_t'(wdata_q[1:0]);
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign do_read       = s_axi_arvalid && s_axi_arready;

    always_comb
    begin
        rd_data = 32'h00000000;
        rd_hit  = 1'b1;
        case (s_axi_araddr)
            `CCM_OFF_CTRL:   rd_data[4:0]  = ctrl_q;
            `CCM_OFF_CMP:    rd_data[15:0] = cmp_q;
            `CCM_OFF_STATUS: rd_data[1:0]  = status_q;
            `CCM_OFF_MASK:   rd_data[1:0]  = mask_q;
            `CCM_OFF_STATE:
            begin
                rd_data[0]   = latch_q;
                rd_data[1]   = pending_q;
                rd_data[2]   = match;
                rd_data[7:4] = ctrl_q.tsel ? ALT_TIMER : `CCM_TIMER_MAIN;
            end
            default:         rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= `CCM_RESP_OKAY;
        end
        else if (do_read)
        begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_data;
            rresp_q  <= rd_hit ? `CCM_RESP_OKAY : `CCM_RESP_SLVERR;
        end
        else if (s_axi_rready)
            rvalid_q <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    equal_sets_flag_a:
    assert property (@(posedge sys_clk) disable iff (rst)
        (is_cmp && sel_count == cmp_q && !$past(match)) |=> status_q.match)
    else $error("equal count did not set match flag");

    flag_with_action_a:
    assert property (@(posedge sys_clk) disable iff (rst)
        $rose(status_q.match) |-> $past(match_rise))
    else $error("match flag set without a match");

    set_mode_a:
    assert property (@(posedge sys_clk) disable iff (rst)
        (match_rise && ctrl_q.mode == `CCM_MODE_SET && !ctrl_zero_wr) |=> latch_q)
    else $error("set mode did not raise latch");

    clear_mode_a:
    assert property (@(posedge sys_clk) disable iff (rst)
        (match_rise && ctrl_q.mode == `CCM_MODE_CLR) |=> !latch_q)
    else $error("clear mode did not lower latch");

    toggle_mode_a:
    assert property (@(posedge sys_clk) disable iff (rst)
        (match_rise && ctrl_q.mode == `CCM_MODE_TOGGLE && !ctrl_zero_wr)
        |=> latch_q != $past(latch_q))
    else $error("toggle mode did not invert latch");

    zero_ctrl_a:
    assert property (@(posedge sys_clk) disable iff (rst)
        ctrl_zero_wr |=> !latch_q && ctrl_q.mode == `CCM_MODE_OFF)
    else $error("zero control write left latch high");

    no_pin_a:
    assert property (@(posedge sys_clk) disable iff (rst)
        (ctrl_q.mode inside {`CCM_MODE_SWI, `CCM_MODE_SPEV}) [*2] |-> !compare_pin_oe)
    else $error("pin driven in interrupt or trigger mode");

    reset_needs_match_a:
    assert property (@(posedge sys_clk) disable iff (rst)
        timer_reset |-> match && sel_tick ##1 !pending_q)
    else $error("timer reset without pending match");

    cancel_pending_a:
    assert property (@(posedge sys_clk) disable iff (rst)
        (pending_q && !match && !special_event_trig) |=> !pending_q)
    else $error("pending reset survived lost match");

    adc_start_a:
    assert property (@(posedge sys_clk) disable iff (rst)
        adc_start |-> special_event_trig && adc_enable && ctrl_q.mode == `CCM_MODE_SPEV)
    else $error("conversion start without trigger");

    tenth_only_a:
    assert property (@(posedge sys_clk) disable iff (rst)
        special_event_trig |-> SPEV_EN)
    else $error("trigger on a channel without it");

    flag_sticky_a:
    assert property (@(posedge sys_clk) disable iff (rst)
        (status_q.match && ev_clr == 2'h0) |=> status_q.match)
    else $error("match flag dropped without a read");

    timer_route_a:
    assert property (@(posedge sys_clk) disable iff (rst)
        timer_reset |-> (timer1_reset != timer_alt_reset) && (timer_alt_reset == ctrl_q.tsel))
    else $error("timer reset sent to wrong timer");

endmodule

`default_nettype wire

// [ccm_cfg.svh]
// Offsets, field positions, encodings and reset values for the compare channel
`ifndef CCM_CFG_SVH
`define CCM_CFG_SVH

`define CCM_ADDR_W        8
`define CCM_OFF_CTRL      8'h00
`define CCM_OFF_CMP       8'h04
`define CCM_OFF_STATUS    8'h08
`define CCM_OFF_MASK      8'h0C
`define CCM_OFF_STATE     8'h10

`define CCM_MODE_OFF      4'h0
`define CCM_MODE_TOGGLE   4'h2
`define CCM_MODE_SET      4'h8
`define CCM_MODE_CLR      4'h9
`define CCM_MODE_SWI      4'hA
`define CCM_MODE_SPEV     4'hB

`define CCM_CTRL_TSEL_BIT 4
`define CCM_EV_MATCH      0
`define CCM_EV_SPEV       1
`define CCM_EV_W          2

`define CCM_CTRL_RST      5'h00
`define CCM_CMP_RST       16'h0000
`define CCM_MASK_RST      2'h0
`define CCM_SPEV_CHANNEL  10
`define CCM_ALT_SPLIT     5
`define CCM_TIMER_MAIN    4'h1
`define CCM_TIMER_LOW     4'h3
`define CCM_TIMER_HIGH    4'h5

`define CCM_RESP_OKAY     2'h0
`define CCM_RESP_SLVERR   2'h2

`endif

// [ccm_pkg.sv]
// Types shared by the compare channel modules
package ccm_pkg;

    typedef struct packed
    {
        logic [15:0] count;
        logic        tick;
    } ccm_timer_t;

    typedef struct packed
    {
        logic       tsel;
        logic [3:0] mode;
    } ccm_ctrl_t;

    typedef struct packed
    {
        logic spev;
        logic match;
    } ccm_events_t;

endpackage

// [ccm_match_unit.sv]
// Equality detector with one-shot match edge
`timescale 1ns/1ps
`default_nettype none

module ccm_match_unit #(
    parameter int W = 16
) (
    input  wire logic         sys_clk,
    input  wire logic         rst,
    input  wire logic         enable,
    input  wire logic [W-1:0] count,
    input  wire logic [W-1:0] value,
    output logic              match,
    output logic              match_rise
);

    logic match_prev_q;

    // Timer holds a value for several system clocks; act once per match
    assign match      = enable && (count == value);
    assign match_rise = match && !match_prev_q;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            match_prev_q <= 1'b0;
        else
            match_prev_q <= match;
    end

endmodule

`default_nettype wire

// [ccm_timer_model.sv]
// Behavioural model of one shared 16-bit timer beside the compare channel
`timescale 1ns/1ps
`default_nettype none

module ccm_timer_model #(
    parameter int DIV = 4
) (
    input  wire logic          sys_clk,
    input  wire logic          rst,
    input  wire logic          clear,
    input  wire logic          timer_reset,
    output var ccm_pkg::ccm_timer_t tmr,
    output logic               ovf_q
);
    logic [7:0]  div_q;
    logic [15:0] cnt_q;

    // Timer clock slower than sys_clk, so every count value lasts several cycles
    assign tmr = '{count: cnt_q, tick: (div_q == 8'(DIV - 1))};

    always_ff @(posedge sys_clk)
    begin
        if (rst || clear)
        begin
            div_q <= 8'h00;
            cnt_q <= 16'h0000;
        end
        else
        begin
            div_q <= tmr.tick ? 8'h00 : div_q + 8'h01;
            if (tmr.tick)
                cnt_q <= timer_reset ? 16'h0000 : cnt_q + 16'h0001;
        end
    end

    // Only a real wrap raises the flag; a trigger reset never does
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            ovf_q <= 1'h0;
        else if (tmr.tick && !timer_reset && cnt_q == 16'hFFFF)
            ovf_q <= 1'h1;
    end
endmodule

`default_nettype wire

// [test_ccm_compare_top.sv]
// Self-checking testbench for the compare channel
`timescale 1ns/1ps
`default_nettype none
`include "ccm_cfg.svh"

module test_ccm_compare_top;
    logic                sys_clk = 1'h0;
    logic                rst = 1'h1;
    logic [7:0]          awaddr = 8'h00;
    logic [7:0]          araddr = 8'h00;
    logic [31:0]         wdata = 32'h0;
    logic                awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic                arvalid = 1'h0, rready = 1'h0, clr = 1'h0;
    logic                pin_dir = 1'h1, adc_en = 1'h0;
    logic                awready, wready, bvalid, arready, rvalid, pin, oe, irq;
    logic                trig, adc_go, rst1, rst5, ovf1, ovf5;
    logic [1:0]          bresp, rresp;
    logic [31:0]         rdata, rd;
    ccm_pkg::ccm_timer_t t1, t5;
    int                  failures = 0, checked = 0, cycles = 0, n, k;
    int                  n_trig = 0, n_adc = 0, n_r1 = 0, n_r5 = 0, b[4];
    logic [7:0]          offs[5] = '{`CCM_OFF_CTRL, `CCM_OFF_CMP, `CCM_OFF_STATUS,
                                     `CCM_OFF_MASK, `CCM_OFF_STATE};
    logic [3:0]          modes[4] = '{`CCM_MODE_TOGGLE, `CCM_MODE_CLR, `CCM_MODE_SET,
                                      `CCM_MODE_SWI};
    logic [3:0]          exp_pin = 4'hD;
    logic [3:0]          exp_oe = 4'h7;

    always #20 sys_clk = ~sys_clk;

    ccm_compare_top #(.CHANNEL_IDX(10)) u_ccm_compare_top (
        .sys_clk(sys_clk), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .timer1_in(t1), .timer_alt_in(t5), .pin_direction_bit(pin_dir), .adc_enable(adc_en),
        .compare_pin_out(pin), .compare_pin_oe(oe), .special_event_trig(trig),
        .adc_start(adc_go), .timer1_reset(rst1), .timer_alt_reset(rst5), .irq(irq)
    );

    // Slow timer clocks leave room to cancel a pending reset over the bus
    ccm_timer_model #(.DIV(12)) u_ccm_timer_model (
        .sys_clk(sys_clk), .rst(rst), .clear(clr), .timer_reset(rst1), .tmr(t1), .ovf_q(ovf1)
    );
    ccm_timer_model #(.DIV(16)) u_ccm_timer_model_alt (
        .sys_clk(sys_clk), .rst(rst), .clear(clr), .timer_reset(rst5), .tmr(t5), .ovf_q(ovf5)
    );

    task automatic give_verdict();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        chk({30'h0, got}, {30'h0, exp}, "bus response");
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
            if (awvalid && awready)
                awvalid <= 1'h0;
            if (wvalid && wready)
                wvalid <= 1'h0;
        end
        while (!bvalid && n < 50);
        bready <= 1'h0;
        chk({31'h0, bvalid}, 32'h1, "write answer");
        chk_resp(bresp, er);
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [1:0] er);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
            if (arvalid && arready)
                arvalid <= 1'h0;
        end
        while (!rvalid && n < 50);
        rd = rdata;
        rready <= 1'h0;
        chk({31'h0, rvalid}, 32'h1, "read answer");
        chk_resp(rresp, er);
    endtask

    task automatic restart_timers();
        @(posedge sys_clk);
        clr <= 1'h1;
        @(posedge sys_clk);
        clr <= 1'h0;
        // Old count is still visible at the clearing edge; wait one more
        @(posedge sys_clk);
    endtask

    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        n_trig <= n_trig + int'(trig);
        n_adc <= n_adc + int'(adc_go);
        n_r1 <= n_r1 + int'(rst1);
        n_r5 <= n_r5 + int'(rst5);
        if (cycles == 20000)
        begin
            failures = failures + 1;
            give_verdict();
        end
    end

    initial
    begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'h0;
        foreach (offs[i])
        begin
            axi_rd(offs[i], `CCM_RESP_OKAY);
            chk(rd, (i == 4) ? 32'h10 : 32'h0, "reset value");
        end
        chk({31'h0, pin}, 32'h0, "latch at reset");
        axi_rd(8'h20, `CCM_RESP_SLVERR);
        chk(rd, 32'h0, "unmapped read");
        axi_wr(8'h20, 32'h1, `CCM_RESP_SLVERR);
        $display("test reset done");

        pin_dir <= 1'h0;
        axi_wr(`CCM_OFF_CMP, 32'h20, `CCM_RESP_OKAY);
        axi_wr(`CCM_OFF_MASK, 32'h1, `CCM_RESP_OKAY);
        for (k = 0; k < 4; k++)
        begin
            axi_wr(`CCM_OFF_CTRL, {28'h0, modes[k]}, `CCM_RESP_OKAY);
            restart_timers();
            for (n = 0; n < 1000 && t1.count != 16'h0021; n++)
                @(posedge sys_clk);
            chk({31'h0, n < 1000}, 32'h1, "timer reached");
            chk({31'h0, pin}, {31'h0, exp_pin[k]}, "latch after match");
            chk({31'h0, oe}, {31'h0, exp_oe[k]}, "pin drive");
            chk({31'h0, irq}, 32'h1, "irq raised");
            axi_rd(`CCM_OFF_STATUS, `CCM_RESP_OKAY);
            chk(rd, 32'h1, "match flag");
            chk({31'h0, irq}, 32'h0, "irq cleared");
        end
        axi_wr(`CCM_OFF_CTRL, 32'h0, `CCM_RESP_OKAY);
        @(posedge sys_clk);
        chk({31'h0, pin}, 32'h0, "latch after zero control");
        $display("test compare modes done");

        axi_wr(`CCM_OFF_MASK, 32'h0, `CCM_RESP_OKAY);
        for (k = 0; k < 2; k++)
        begin
            adc_en <= k[0];
            axi_wr(`CCM_OFF_CMP, 32'h10, `CCM_RESP_OKAY);
            axi_wr(`CCM_OFF_CTRL, {27'h0, k[0], `CCM_MODE_SPEV}, `CCM_RESP_OKAY);
            restart_timers();
            b = '{n_trig, n_adc, n_r1, n_r5};
            for (n = 0; n < 3000 && n_trig - b[0] < 4; n++)
                @(posedge sys_clk);
            // Moving the compare value away drops the fourth pending reset
            axi_wr(`CCM_OFF_CMP, 32'h100, `CCM_RESP_OKAY);
            for (n = 0; n < 1000 && (k ? t5.count : t1.count) != 16'h0014; n++)
                @(posedge sys_clk);
            chk({31'h0, n < 1000}, 32'h1, "count after cancel");
            chk(n_trig - b[0], 32'h4, "trigger pulses");
            chk(n_adc - b[1], 4 * k, "conversion starts");
            chk(n_r1 - b[2], k ? 0 : 3, "timer 1 resets");
            chk(n_r5 - b[3], k ? 3 : 0, "alt timer resets");
            chk({30'h0, ovf5, ovf1}, 32'h0, "overflow flags");
            chk({31'h0, oe}, 32'h0, "pin released");
            chk({31'h0, irq}, 32'h0, "irq masked");
            axi_wr(`CCM_OFF_MASK, 32'h2, `CCM_RESP_OKAY);
            chk({31'h0, irq}, 32'h1, "irq unmasked");
            axi_rd(`CCM_OFF_STATUS, `CCM_RESP_OKAY);
            chk(rd, 32'h3, "match and event flags");
            axi_rd(`CCM_OFF_STATE, `CCM_RESP_OKAY);
            chk({28'h0, rd[7:4]}, {28'h0, k ? `CCM_TIMER_HIGH : `CCM_TIMER_MAIN},
                "selected timer");
            axi_wr(`CCM_OFF_MASK, 32'h0, `CCM_RESP_OKAY);
        end
        $display("test special event done");
        give_verdict();
    end
endmodule

`default_nettype wire
